//--- core/snvc_core.sv
// serial nvram command, protection and array core, spi slave side
`timescale 1ns/1ps
module snvc_core (
    input wire logic core_clk,
    input wire logic arst_n,
    // spi link, sck is the link domain clock
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // observation
    output logic mode3,
    output logic write_latch_flag
);
    import snvc_pkg::*;

    // ---------------- link domain (sck) ----------------

    snvc_state_e state_q;
    logic [2:0] cnt_q;
    logic [6:0] sh_q;
    logic [ADDR_W-1:0] addr_q;
    logic addr_hi_q;
    logic rd_q;
    logic stop_q;
    logic [6:0] osh_q;
    logic so_q;
    logic so_oe_q;
    logic [2:0] tog_q;
    logic [STAT_W-1:0] sw_data_q;
    logic [STAT_W-1:0] stat_l1_q;
    logic [STAT_W-1:0] stat_l2_q;
    // published by the core domain, held still while a frame runs
    logic [STAT_W-1:0] stat_pub_q;
    // array powers up cleared, standing in for its factory contents
    logic [7:0] mem [MEM_DEPTH] = '{default: '0};

    wire [7:0] byte_in = {sh_q, si};
    wire byte_done = hold_n && (cnt_q == LAST_BIT);
    wire wl_l = stat_l2_q[ST_WL_BIT];
    wire [1:0] bp_l = {stat_l2_q[ST_BPH_BIT], stat_l2_q[ST_BPL_BIT]};

    // array guard uses latch and protect bits only, never the pin
    wire wr_allow = wl_l && !snvc_is_protected(addr_q, bp_l);
    wire in_wdata = (state_q == SNVC_WDATA);
    wire wr_commit = in_wdata && byte_done && wr_allow && !stop_q;
    wire opc_done = (state_q == SNVC_OPC) && byte_done;
    wire ev_set_l = opc_done && (byte_in == OPC_SET_WL);
    wire ev_arm_l = opc_done && (byte_in == OPC_CLR_WL
                                || byte_in == OPC_WR_STAT
                                || byte_in == OPC_WRITE);
    wire ev_sw_l = (state_q == SNVC_SWR) && byte_done;
    wire shifting = (state_q == SNVC_RDATA) || (state_q == SNVC_RSR);
    wire [7:0] out_byte = (state_q == SNVC_RSR) ? stat_l2_q : mem[addr_q];

    // frame state is cleared by chip select itself, since sck stops
    // outside a frame and cannot be trusted to deliver a last edge
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            state_q <= SNVC_OPC;
            cnt_q <= 3'h0;
            sh_q <= 7'h00;
            addr_q <= '0;
            addr_hi_q <= 1'b0;
            rd_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (hold_n) begin
            cnt_q <= cnt_q + 3'h1;
            sh_q <= byte_in[6:0];
            if (cnt_q == LAST_BIT) begin
                unique case (state_q)
                    SNVC_OPC: begin
                        unique case (byte_in)
                            OPC_SET_WL: state_q <= SNVC_DONE;
                            OPC_CLR_WL: state_q <= SNVC_DONE;
                            OPC_RD_STAT: state_q <= SNVC_RSR;
                            OPC_WR_STAT: state_q <= SNVC_SWR;
                            OPC_READ: begin
                                state_q <= SNVC_ADDR;
                                rd_q <= 1'b1;
                            end
                            OPC_WRITE: begin
                                state_q <= SNVC_ADDR;
                                rd_q <= 1'b0;
                            end
                            default: state_q <= SNVC_IGN;
                        endcase
                    end
                    SNVC_ADDR: begin
                        // top three address bits are dropped
                        if (!addr_hi_q) begin
                            addr_q[ADDR_W-1:8] <= byte_in[4:0];
                            addr_hi_q <= 1'b1;
                        end else begin
                            addr_q[7:0] <= byte_in;
                            state_q <= rd_q ? SNVC_RDATA : SNVC_WDATA;
                        end
                    end
                    SNVC_WDATA: begin
                        if (wr_allow && !stop_q) begin
                            addr_q <= addr_q + 13'h1;
                        end else begin
                            stop_q <= 1'b1;
                        end
                    end
                    SNVC_RDATA: addr_q <= addr_q + 13'h1;
                    SNVC_SWR: state_q <= SNVC_DONE;
                    SNVC_RSR: state_q <= SNVC_DONE;
                    SNVC_IGN: state_q <= SNVC_IGN;
                    SNVC_DONE: state_q <= SNVC_DONE;
                endcase
            end
        end
    end

    // array and captured status byte hold no reset: nonvolatile
    always_ff @(posedge sck) begin
        if (wr_commit) begin
            mem[addr_q] <= byte_in;
        end
        if (ev_sw_l) begin
            sw_data_q <= byte_in;
        end
    end

    // event toggles to the core domain: set, arm clear, status write
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            tog_q <= 3'h0;
        end else begin
            tog_q <= tog_q ^ {ev_sw_l, ev_arm_l, ev_set_l};
        end
    end

    // status copy only changes between frames; by the first byte
    // boundary at least seven edges have flushed these two stages
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            stat_l1_q <= STAT_RESET;
            stat_l2_q <= STAT_RESET;
        end else begin
            stat_l1_q <= stat_pub_q;
            stat_l2_q <= stat_l1_q;
        end
    end

    // output shifts on falling sck; serial in is not looked at here
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            osh_q <= 7'h00;
        end else if (hold_n) begin
            so_oe_q <= shifting;
            if (shifting && cnt_q == 3'h0) begin
                so_q <= out_byte[7];
                osh_q <= out_byte[6:0];
            end else begin
                so_q <= osh_q[6];
                osh_q <= {osh_q[5:0], 1'b0};
            end
        end
    end

    assign so = so_q;
    assign so_oe = so_oe_q;

    // ---------------- core domain (core_clk) ----------------

    logic [2:0] cs_sy_q;
    logic [1:0] sck_sy_q;
    logic [1:0] wp_sy_q;
    logic [2:0] tog_s1_q;
    logic [2:0] tog_s2_q;
    logic [2:0] tog_s3_q;
    logic mode3_q;
    logic wl_out_q;
    logic [STAT_W-1:0] status;
    logic latch;

    wire cs_rise = cs_sy_q[1] && !cs_sy_q[2];
    wire cs_fall = !cs_sy_q[1] && cs_sy_q[2];
    wire [2:0] tog_ev = tog_s2_q ^ tog_s3_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_sy_q <= 3'h7;
            sck_sy_q <= 2'h0;
            wp_sy_q <= 2'h3;
            tog_s1_q <= 3'h0;
            tog_s2_q <= 3'h0;
            tog_s3_q <= 3'h0;
        end else begin
            cs_sy_q <= {cs_sy_q[1:0], cs_n};
            sck_sy_q <= {sck_sy_q[0], sck};
            wp_sy_q <= {wp_sy_q[0], wp_n};
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    snvc_status u_status (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set_ev(tog_ev[0]),
        .arm_ev(tog_ev[1]),
        .sw_ev(tog_ev[2]),
        .cs_rise(cs_rise),
        .wp_n_s(wp_sy_q[1]),
        .sw_data(sw_data_q),
        .status(status),
        .latch(latch)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_pub_q <= STAT_RESET;
            mode3_q <= 1'b0;
            wl_out_q <= WL_RESET;
        end else begin
            // publish only while deselected so the link sees a stable word
            if (cs_sy_q[1]) begin
                stat_pub_q <= status;
            end
            if (cs_fall) begin
                mode3_q <= sck_sy_q[1];
            end
            wl_out_q <= latch;
        end
    end

    assign mode3 = mode3_q;
    assign write_latch_flag = wl_out_q;

endmodule : snvc_core

//--- core/snvc_pkg.sv
// shared constants, types and decode functions of the serial nvram core
package snvc_pkg;

    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam int STAT_W = 8;
    localparam int NV_W = 3;

    // opcodes, first byte of every selected cycle
    localparam logic [7:0] OPC_SET_WL = 8'h06;
    localparam logic [7:0] OPC_CLR_WL = 8'h04;
    localparam logic [7:0] OPC_RD_STAT = 8'h05;
    localparam logic [7:0] OPC_WR_STAT = 8'h01;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;

    // status byte layout
    localparam int ST_PROTECT_PIN_ENABLE_BIT = 7;
    localparam int ST_BPH_BIT = 3;
    localparam int ST_BPL_BIT = 2;
    localparam int ST_WL_BIT = 1;

    // reset and factory values
    localparam logic [NV_W-1:0] NV_FACTORY = 3'h0;
    localparam logic WL_RESET = 1'b0;
    localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;

    // block protect boundaries
    localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 13'h1800;
    localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 13'h1000;

    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        SNVC_OPC, SNVC_ADDR, SNVC_WDATA, SNVC_RDATA,
        SNVC_SWR, SNVC_RSR, SNVC_IGN, SNVC_DONE
    } snvc_state_e;

    function automatic logic snvc_is_protected(
        input logic [ADDR_W-1:0] a,
        input logic [1:0] bp
    );
        logic p;
        unique case (bp)
            2'b00: p = 1'b0;
            2'b01: p = (a >= PROT_QTR_BASE);
            2'b10: p = (a >= PROT_HALF_BASE);
            2'b11: p = 1'b1;
        endcase
        return p;
    endfunction : snvc_is_protected

    function automatic logic [STAT_W-1:0] snvc_status_byte(
        input logic protect_pin_enable,
        input logic [1:0] bp,
        input logic wl
    );
        logic [STAT_W-1:0] s;
        s = STAT_RESET;
        s[ST_PROTECT_PIN_ENABLE_BIT] = protect_pin_enable;
        s[ST_BPH_BIT] = bp[1];
        s[ST_BPL_BIT] = bp[0];
        s[ST_WL_BIT] = wl;
        return s;
    endfunction : snvc_status_byte

endpackage : snvc_pkg

//--- core/snvc_status.sv
// write latch, nonvolatile protect bits and status write acceptance
`timescale 1ns/1ps
module snvc_status (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic set_ev,
    input wire logic arm_ev,
    input wire logic sw_ev,
    input wire logic cs_rise,
    input wire logic wp_n_s,
    input wire logic [snvc_pkg::STAT_W-1:0] sw_data,
    output logic [snvc_pkg::STAT_W-1:0] status,
    output logic latch
);
    import snvc_pkg::*;

    logic wl_q;
    logic armed_q;
    // nonvolatile: survives arst_n, starts at the factory value
    logic [NV_W-1:0] nv_q = NV_FACTORY;

    wire protect_pin_enable = nv_q[2];
    wire clr_now = cs_rise && (armed_q || arm_ev);
    // pin only guards the status byte, and only when enabled
    wire pin_block = protect_pin_enable && !wp_n_s;
    wire sw_ok = sw_ev && wl_q && !pin_block;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wl_q <= WL_RESET;
            armed_q <= 1'b0;
        end else begin
            if (set_ev) begin
                wl_q <= 1'b1;
            end else if (clr_now) begin
                wl_q <= 1'b0;
            end
            // a chip select rise always disarms, even when the arm
            // event lands in the same cycle, so no stale clear survives
            armed_q <= !cs_rise && (arm_ev || armed_q);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sw_ok) begin
            nv_q <= {sw_data[ST_PROTECT_PIN_ENABLE_BIT], sw_data[ST_BPH_BIT],
                     sw_data[ST_BPL_BIT]};
        end
    end

    // written latch bit is dropped on purpose
    assign status = snvc_status_byte(protect_pin_enable, nv_q[1:0], wl_q);
    assign latch = wl_q;

endmodule : snvc_status

//--- testbench/snvc_core_checker.sv
// concurrent port checks of the serial nvram core
`timescale 1ns/1ps
module snvc_core_checker (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic mode3,
    input wire logic write_latch_flag
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    chk_latch_at_reset: assert property (
        $rose(arst_n) |-> !write_latch_flag)
        else $error("latch set right after reset");
    // the latch may settle a few cycles after deselect, not later
    chk_latch_idle_still: assert property (
        cs_n [*8] |=> $stable(write_latch_flag))
        else $error("latch moved while deselected");
    chk_latch_clear_edge: assert property (
        $fell(write_latch_flag) |-> cs_n)
        else $error("latch cleared inside a frame");
    chk_latch_set_frame: assert property (
        $rose(write_latch_flag) |-> !$past(cs_n, 2))
        else $error("latch set outside a frame");
    chk_oe_in_frame: assert property (
        so_oe |-> !cs_n)
        else $error("serial out driven while deselected");
    chk_oe_rise_low: assert property (
        $rose(so_oe) |-> !sck)
        else $error("serial out enabled off the falling clock");
    chk_so_change_low: assert property (
        so_oe && $past(so_oe) && $changed(so) |-> !sck)
        else $error("serial out changed while clock high");
    chk_pause_freezes: assert property (
        !hold_n && !$past(hold_n) && !cs_n |-> $stable(so) && $stable(so_oe))
        else $error("serial out moved during pause");
    // mode lands three cycles after select falls, then must hold
    chk_mode_in_frame: assert property (
        !cs_n [*4] |=> $stable(mode3))
        else $error("mode changed inside a frame");
    cover property ($rose(so_oe));
    cover property ($fell(write_latch_flag));
    cover property ($rose(mode3));
    cover property ($fell(hold_n));
endmodule : snvc_core_checker
bind snvc_core snvc_core_checker u_chk (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .hold_n(hold_n),
    .wp_n(wp_n),
    .so(so),
    .so_oe(so_oe),
    .mode3(mode3),
    .write_latch_flag(write_latch_flag)
);

//--- testbench/snvc_spi_master.sv
// spi master model facing the serial nvram core
`timescale 1ns/1ps
module snvc_spi_master (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    logic idle_hi = 1'b0;
    // no pull on the line, so a floating output reads as z
    wire so_line = so_oe ? so : 1'bz;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic open_frame(input logic m3);
        idle_hi = m3;
        sck = m3;
        #40;
        cs_n = 1'b0;
        // let the core sample the idle clock level before it moves
        #60;
    endtask : open_frame
    task automatic shift(input logic [7:0] b, input int n,
                         output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            si = b[7-i];
            #62.5;
            sck = 1'b1;
            r = {r[6:0], so_line};
            #62.5;
        end
    endtask : shift
    task automatic close_frame();
        sck = idle_hi;
        #62.5;
        cs_n = 1'b1;
        si = ~si;
        #200;
    endtask : close_frame
    // garbage clocks during the pause must not advance the frame
    task automatic pause_run();
        sck = 1'b0;
        #20;
        hold_n = 1'b0;
        repeat (3) begin
            si = ~si;
            #62.5;
            sck = 1'b1;
            #62.5;
            sck = 1'b0;
        end
        #20;
        hold_n = 1'b1;
    endtask : pause_run
endmodule : snvc_spi_master

//--- testbench/spi_nvram_command_protect_core_test.sv
// self-checking bench of the serial nvram core against a model
`timescale 1ns/1ps
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module spi_nvram_command_protect_core_test;
    import snvc_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, hold_n, so, so_oe, mode3, write_latch_flag;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] rs = 32'h18;
    logic [7:0] mem [MEM_DEPTH];
    logic wl, protect_pin_enable;
    logic [1:0] bp;
    logic [12:0] starts [3] = '{13'h0ffe, 13'h17fe, 13'h1ffe};
    always #10 core_clk = ~core_clk;
    snvc_core i_dut (.core_clk(core_clk), .arst_n(arst_n), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
        .so_oe(so_oe), .mode3(mode3), .write_latch_flag(write_latch_flag));
    snvc_spi_master u_m (.sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .so(so), .so_oe(so_oe));
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd
    function automatic logic prot(input int a);
        return bp == 2'b11 || (bp == 2'b10 && a >= 'h1000) ||
            (bp == 2'b01 && a >= 'h1800);
    endfunction : prot
    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        u_m.open_frame(1'b0);
        u_m.shift(op, 8, r);
        u_m.close_frame();
    endtask : cmd
    task automatic set_wl();
        cmd(OPC_SET_WL);
        wl = 1'b1;
    endtask : set_wl
    task automatic chk_stat(input logic m3);
        logic [7:0] r;
        `CMP(write_latch_flag, wl)
        u_m.open_frame(m3);
        u_m.shift(OPC_RD_STAT, 8, r);
        u_m.shift(8'(rnd()), 8, r);
        `CMP(r, {protect_pin_enable, 3'h0, bp, wl, 1'b0})
        `CMP(mode3, m3)
        u_m.close_frame();
    endtask : chk_stat
    task automatic wr_stat(input logic [7:0] d);
        logic [7:0] r;
        u_m.open_frame(1'b0);
        u_m.shift(OPC_WR_STAT, 8, r);
        u_m.shift(d, 8, r);
        u_m.close_frame();
        if (wl && !(protect_pin_enable && !wp_n)) begin
            protect_pin_enable = d[7];
            bp = d[3:2];
        end
        wl = 1'b0;
    endtask : wr_stat
    task automatic wr_mem(input logic [15:0] a0, input int n, input int tail);
        logic [7:0] r, d;
        int a;
        logic stop;
        a = a0[12:0];
        stop = 1'b0;
        u_m.open_frame(1'b0);
        u_m.shift(OPC_WRITE, 8, r);
        u_m.shift(a0[15:8], 8, r);
        u_m.shift(a0[7:0], 8, r);
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            if (i == 1) u_m.pause_run();
            u_m.shift(d, 8, r);
            if (!wl || prot(a)) stop = 1'b1;
            if (!stop) begin
                mem[a] = d;
                a = (a + 1) % MEM_DEPTH;
            end
        end
        u_m.shift(8'(rnd()), tail, r);
        u_m.close_frame();
        wl = 1'b0;
    endtask : wr_mem
    task automatic rd_mem(input logic [15:0] a0, input int n);
        logic [7:0] r;
        int a;
        a = a0[12:0];
        u_m.open_frame(1'b0);
        u_m.shift(OPC_READ, 8, r);
        u_m.shift(a0[15:8], 8, r);
        u_m.shift(a0[7:0], 8, r);
        for (int i = 0; i < n; i++) begin
            u_m.shift(8'(rnd()), 8, r);
            `CMP(r, mem[a])
            a = (a + 1) % MEM_DEPTH;
        end
        u_m.close_frame();
    endtask : rd_mem
    task automatic close_out();
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        #1500000;
        errors++;
        close_out();
    end
    initial begin
        logic [15:0] a;
        for (int i = 0; i < MEM_DEPTH; i++) mem[i] = 8'h00;
        wl = 1'b0;
        protect_pin_enable = 1'b0;
        bp = 2'b00;
        repeat (20) @(negedge core_clk);
        arst_n <= 1'b1;
        repeat (6) @(negedge core_clk);
        chk_stat(1'b0);
        wr_mem(16'h0010, 2, 0);
        rd_mem(16'h0010, 2);
        set_wl();
        chk_stat(1'b1);
        cmd(OPC_CLR_WL);
        wl = 1'b0;
        chk_stat(1'b0);
        set_wl();
        wr_stat(8'hff);
        chk_stat(1'b0);
        @(negedge core_clk) wp_n <= 1'b0;
        set_wl();
        wr_stat(8'h00);
        chk_stat(1'b0);
        set_wl();
        cmd(8'hb7);
        chk_stat(1'b0);
        @(negedge core_clk) wp_n <= 1'b1;
        wr_stat(8'h00);
        for (int k = 0; k < 4; k++) begin
            set_wl();
            wr_stat({6'h00, 2'(k)} << 2);
            foreach (starts[j]) begin
                @(negedge core_clk) wp_n <= 1'(rnd());
                a = {3'(rnd()), starts[j]};
                set_wl();
                wr_mem(a, 4, 5);
                rd_mem(a, 4);
            end
        end
        @(negedge core_clk) arst_n <= 1'b0;
        repeat (3) @(negedge core_clk);
        arst_n <= 1'b1;
        wl = 1'b0;
        repeat (6) @(negedge core_clk);
        chk_stat(1'b1);
        close_out();
    end
endmodule : spi_nvram_command_protect_core_test
